// ==== logic/uart_fifo_status_timeout.sv ====
// Serial port with transmit and receive queues, queue status flags, gap timeout and flushes.
// Assumes one AHB-Lite master, one clock core_clk, and an asynchronous serial line on rxd/txd.
//
// What this block does
// RL1: Overrun flag when character meets full queue.
// RL2: Frame fault flag while queue holds framing error.
// RL3: Parity fault flag while queue holds parity error.
// RL4: Transmit half-vacant flag while half entries free.
// RL5: Transmitter idle flag while shifter is empty.
// RL6: Receive entry flag while receive queue nonempty.
// RL7: Eight-bit gap limit counted in baud ticks.
// RL8: Timeout register upper bits read as zero.
// RL9: Timeout register at 1Ch, reset zero.
// RL10: Any write to 20h empties transmit queue.
// RL11: Any write to 24h empties receive queue.
// RL12: Transmit full flag at sixteen characters.
// RL13: Receive half-full flag at eight or more.
// RL14: Timeout sets empty or pending flag by occupancy.
// RL15: Interrupt while enabled status flag is set.
// RL16: Gap counter restarts per character, fires at limit.
`default_nettype none

module uart_fifo_status_timeout
  import uart_pkg::*;
#(
  parameter int unsigned QUEUE_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial line.
  input  wire logic        rxd,
  output logic             txd,
  // Interrupt request.
  output logic             irq
);

  localparam int PW = $clog2(QUEUE_DEPTH);
  localparam int CW = $clog2(QUEUE_DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(QUEUE_DEPTH);
  localparam logic [CW-1:0] HALF_C  = CW'(QUEUE_DEPTH / 2);

  // Pointers wrap naturally, so the depth must be a power of two.
  if (QUEUE_DEPTH < 2 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("QUEUE_DEPTH must be a power of two of at least 2");
  end

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

  // ****************************************************************
  // Registers and shared wires.
  // ****************************************************************
  logic [15:0]       baud_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [STAT_W-1:0] mask_q;
  logic [GAP_W-1:0]  gap_limit_q;
  logic [STAT_W-1:0] sticky_q;
  logic [STAT_W-1:0] status_w;
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  logic              rd_take_w;
  logic              wr_now_w;
  logic [31:0]       rdata_w;
  logic              run_w;
  logic              parity_on_w;

  assign run_w       = ctrl_q[CTL_RUN];
  assign parity_on_w = (ctrl_q[CTL_MODE_LO +: 3] == MODE_8_PARITY);

  // ****************************************************************
  // Bus slave: zero wait states, read data captured at the address phase.
  // ****************************************************************
  assign rd_take_w = hsel & hready & htrans[1] & ~hwrite;
  assign wr_now_w  = wr_pend_q;

  // Write address is held from the address phase into the data phase.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Every transfer completes at once with an OKAY answer.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_take_w) begin
        hrdata <= rdata_w;
      end
    end
  end

  // ****************************************************************
  // Configuration registers written by software.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_q      <= BAUD_RST;
      ctrl_q      <= CTRL_RST;
      mask_q      <= MASK_RST;
      gap_limit_q <= GAP_RST;                            // RL9
    end else if (wr_now_w) begin
      unique case (wr_addr_q)
        OFS_BAUD: baud_q      <= hwdata[15:0];
        OFS_CTRL: ctrl_q      <= hwdata[CTRL_W-1:0];
        OFS_MASK: mask_q      <= hwdata[STAT_W-1:0];
        OFS_GAP:  gap_limit_q <= hwdata[GAP_W-1:0];      // RL7
        default:  ;
      endcase
    end
  end

  // ****************************************************************
  // Oversampling tick and bit-rate tick for the gap counter.
  // ****************************************************************
  logic [15:0]     div_q;
  logic            os_tick_w;
  logic [OS_W-1:0] gap_os_q;
  logic            bit_tick_w;

  assign os_tick_w  = run_w && (div_q == baud_q);
  assign bit_tick_w = os_tick_w && (gap_os_q == OS_LAST);

  // Divider is held at zero while the port is stopped.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q    <= 16'h0000;
      gap_os_q <= '0;
    end else if (!run_w || os_tick_w) begin
      div_q <= 16'h0000;
      if (os_tick_w) begin
        gap_os_q <= gap_os_q + 1'b1;
      end
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Transmit queue and shifter.
  // ****************************************************************
  logic [7:0]      tx_mem [QUEUE_DEPTH];
  logic [PW-1:0]   tx_wp_q;
  logic [PW-1:0]   tx_rp_q;
  logic [CW-1:0]   tx_cnt_q;
  logic            tx_push_w;
  logic            tx_pop_w;
  logic            tx_flush_w;
  logic            tx_busy_q;
  logic [10:0]     tx_shift_q;
  logic [3:0]      tx_bits_q;
  logic [OS_W-1:0] tx_os_q;

  assign tx_flush_w = wr_now_w && (wr_addr_q == OFS_TXFL);
  assign tx_push_w  = wr_now_w && (wr_addr_q == OFS_TXH) && (tx_cnt_q != DEPTH_C);
  assign tx_pop_w   = run_w && !tx_busy_q && (tx_cnt_q != '0) && !tx_flush_w;

  // A write to a full queue is dropped; a flush wins over a push in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else if (tx_flush_w) begin
      tx_wp_q  <= '0;                                    // RL10
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push_w) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_pop_w) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      tx_cnt_q <= tx_cnt_q + CW'(tx_push_w) - CW'(tx_pop_w);
    end
  end

  // Queue storage needs no reset; only counted entries are ever read.
  always_ff @(posedge core_clk) begin
    if (tx_push_w) begin
      tx_mem[tx_wp_q] <= hwdata[7:0];
    end
  end

  // Frame: start bit, eight data bits, parity, one stop bit, LSB first; with parity off the parity bit is sent in place of data bit 7.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_q  <= 1'b0;
      tx_shift_q <= '1;
      tx_bits_q  <= 4'h0;
      tx_os_q    <= '0;
      txd        <= 1'b1;
    end else if (tx_pop_w) begin
      tx_busy_q  <= 1'b1;
      tx_shift_q <= {1'b1, ^tx_mem[tx_rp_q] ^ ctrl_q[CTL_PARITY_ODD], tx_mem[tx_rp_q], 1'b0};
      tx_bits_q  <= parity_on_w ? 4'hB : 4'hA;
      tx_os_q    <= '0;
    end else if (tx_busy_q && os_tick_w) begin
      txd     <= tx_shift_q[0];
      tx_os_q <= tx_os_q + 1'b1;
      if (tx_os_q == OS_LAST) begin
        tx_shift_q <= parity_on_w || tx_bits_q != 4'h3
                      ? {1'b1, tx_shift_q[10:1]} : {2'b11, tx_shift_q[10:2]};
        tx_bits_q  <= tx_bits_q - 4'h1;
        tx_busy_q  <= (tx_bits_q != 4'h1);
      end
    end else if (!tx_busy_q) begin
      txd <= 1'b1;
    end
  end

  // ****************************************************************
  // Receive line synchroniser and deserialiser.
  // ****************************************************************
  logic            rxd_meta_q;
  logic            rxd_q;
  rx_state_e       rx_state_q;
  logic [OS_W-1:0] rx_os_q;
  logic [2:0]      rx_idx_q;
  logic [7:0]      rx_data_q;
  logic            rx_pe_q;
  logic            rx_done_w;
  rx_entry_s       rx_new_w;

  // Two stages before any logic looks at the pin.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta_q <= 1'b1;
      rxd_q      <= 1'b1;
    end else begin
      rxd_meta_q <= rxd;
      rxd_q      <= rxd_meta_q;
    end
  end

  assign rx_done_w = (rx_state_q == RX_STOP) && os_tick_w && (rx_os_q == OS_LAST);
  assign rx_new_w  = '{frame_err: ~rxd_q, parity_err: rx_pe_q, data: rx_data_q};

  // A start edge is confirmed at mid-bit, then each bit is sampled one bit later.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_os_q    <= '0;
      rx_idx_q   <= 3'h0;
      rx_data_q  <= 8'h00;
      rx_pe_q    <= 1'b0;
    end else if (!run_w || !ctrl_q[CTL_RX_EN]) begin
      rx_state_q <= RX_IDLE;
    end else if (os_tick_w) begin
      rx_os_q <= rx_os_q + 1'b1;
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_os_q <= '0;
          if (!rxd_q) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_os_q == OS_MID) begin
            rx_os_q    <= '0;
            rx_idx_q   <= 3'h0;
            rx_pe_q    <= 1'b0;
            rx_state_q <= rxd_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_os_q == OS_LAST) begin
            rx_data_q <= {rxd_q, rx_data_q[7:1]};
            rx_idx_q  <= rx_idx_q + 3'h1;
            if (rx_idx_q == 3'h7) begin
              rx_state_q <= parity_on_w ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_os_q == OS_LAST) begin
            rx_pe_q    <= (^rx_data_q ^ ctrl_q[CTL_PARITY_ODD]) != rxd_q;
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_os_q == OS_LAST) begin
            rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Receive queue with running counts of faulty entries.
  // ****************************************************************
  rx_entry_s     rx_mem [QUEUE_DEPTH];
  logic [PW-1:0] rx_wp_q;
  logic [PW-1:0] rx_rp_q;
  logic [CW-1:0] rx_cnt_q;
  logic [CW-1:0] fe_cnt_q;
  logic [CW-1:0] pe_cnt_q;
  logic          rx_full_w;
  logic          rx_push_w;
  logic          rx_pop_w;
  logic          rx_flush_w;
  rx_entry_s     rx_head_w;

  assign rx_full_w  = (rx_cnt_q == DEPTH_C);
  assign rx_flush_w = wr_now_w && (wr_addr_q == OFS_RXFL);
  assign rx_push_w  = rx_done_w && !rx_full_w;
  assign rx_head_w  = rx_mem[rx_rp_q];
  assign rx_pop_w   = rd_take_w && (haddr[7:0] == OFS_RXH) && (rx_cnt_q != '0);

  // Counting faulty entries keeps both fault flags exact without scanning storage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
      fe_cnt_q <= '0;
      pe_cnt_q <= '0;
    end else if (rx_flush_w) begin
      rx_wp_q  <= '0;                                    // RL11
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
      fe_cnt_q <= '0;
      pe_cnt_q <= '0;
    end else begin
      if (rx_push_w) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop_w) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      rx_cnt_q <= rx_cnt_q + CW'(rx_push_w) - CW'(rx_pop_w);
      fe_cnt_q <= fe_cnt_q + CW'(rx_push_w && rx_new_w.frame_err)
                  - CW'(rx_pop_w && rx_head_w.frame_err);
      pe_cnt_q <= pe_cnt_q + CW'(rx_push_w && rx_new_w.parity_err)
                  - CW'(rx_pop_w && rx_head_w.parity_err);
    end
  end

  // Storage for received characters.
  always_ff @(posedge core_clk) begin
    if (rx_push_w) begin
      rx_mem[rx_wp_q] <= rx_new_w;
    end
  end

  // ****************************************************************
  // Inter-character gap counter.
  // ****************************************************************
  logic [GAP_W-1:0] gap_cnt_q;
  logic             gap_armed_q;
  logic             gap_fire_w;

  assign gap_fire_w = gap_armed_q && bit_tick_w && (gap_limit_q != '0)
                      && (gap_cnt_q + 1'b1 == gap_limit_q);

  // Armed by each received character, fires once per silent gap; a zero limit disables it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_q   <= '0;
      gap_armed_q <= 1'b0;
    end else if (rx_done_w) begin
      gap_cnt_q   <= '0;                                 // RL16
      gap_armed_q <= 1'b1;
    end else if (gap_fire_w) begin
      gap_armed_q <= 1'b0;                               // RL16
    end else if (gap_armed_q && bit_tick_w) begin
      gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // Sticky event flags: a new event beats a write-one-to-clear.
  // ****************************************************************
  logic [STAT_W-1:0] set_w;
  logic [STAT_W-1:0] clr_w;

  always_comb begin
    set_w               = '0;
    set_w[ST_OVERRUN]   = rx_done_w && rx_full_w;                     // RL1
    set_w[ST_GAP_EMPTY] = gap_fire_w && (rx_cnt_q == '0);             // RL14
    set_w[ST_GAP_PEND]  = gap_fire_w && (rx_cnt_q != '0);             // RL14
    clr_w               = '0;
    if (wr_now_w && wr_addr_q == OFS_STAT) begin
      clr_w = hwdata[STAT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sticky_q <= '0;
    end else begin
      sticky_q <= set_w | (sticky_q & ~clr_w);
    end
  end

  // ****************************************************************
  // Status word, read mux and interrupt.
  // ****************************************************************
  always_comb begin
    status_w               = sticky_q;
    status_w[ST_RX_ENTRY]  = (rx_cnt_q != '0);                        // RL6
    status_w[ST_TX_IDLE]   = !tx_busy_q;                              // RL5
    status_w[ST_TX_HALF]   = (DEPTH_C - tx_cnt_q) >= HALF_C;          // RL4
    status_w[ST_PARITY]    = (pe_cnt_q != '0);                        // RL3
    status_w[ST_FRAME]     = (fe_cnt_q != '0);                        // RL2
    status_w[ST_RX_HALF]   = rx_cnt_q >= HALF_C;                      // RL13
    status_w[ST_TX_FULL]   = (tx_cnt_q == DEPTH_C);                   // RL12
  end

  // Unmapped and write-only offsets read as zero.
  always_comb begin
    rdata_w = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_BAUD: rdata_w[15:0]       = baud_q;
      OFS_RXH: begin
        if (rx_cnt_q != '0) begin
          rdata_w[7:0]      = rx_head_w.data;
          rdata_w[RX_PE_BIT] = rx_head_w.parity_err;
          rdata_w[RX_FE_BIT] = rx_head_w.frame_err;
        end
      end
      OFS_CTRL: rdata_w[CTRL_W-1:0] = ctrl_q;
      OFS_MASK: rdata_w[STAT_W-1:0] = mask_q;
      OFS_STAT: rdata_w[STAT_W-1:0] = status_w;
      OFS_GAP:  rdata_w[GAP_W-1:0]  = gap_limit_q;                    // RL8
      default:  ;
    endcase
  end

  // Registered so the request line is glitch free.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_w & mask_q);                                    // RL15
    end
  end

  logic unused_w;
  assign unused_w = ^{haddr[31:8], hsize, htrans[0], hwdata[31:16]};

endmodule : uart_fifo_status_timeout

`default_nettype wire

// ==== logic/uart_pkg.sv ====
// Constants and carrier types shared by the serial port queue and status block.
// Assumes a 32-bit AHB-Lite register bus and byte offsets within one 256-byte window.
`default_nettype none

package uart_pkg;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] OFS_BAUD   = 8'h00;
  localparam logic [7:0] OFS_TXH    = 8'h04;
  localparam logic [7:0] OFS_RXH    = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;
  localparam logic [7:0] OFS_GAP    = 8'h1C;
  localparam logic [7:0] OFS_TXFL   = 8'h20;
  localparam logic [7:0] OFS_RXFL   = 8'h24;

  // ****************************************************************
  // Status and mask bit positions (same layout for both).
  // ****************************************************************
  localparam int ST_RX_ENTRY  = 0;
  localparam int ST_TX_IDLE   = 1;
  localparam int ST_TX_HALF   = 2;
  localparam int ST_PARITY    = 3;
  localparam int ST_FRAME     = 4;
  localparam int ST_OVERRUN   = 5;
  localparam int ST_GAP_PEND  = 6;
  localparam int ST_GAP_EMPTY = 7;
  localparam int ST_RX_HALF   = 8;
  localparam int ST_TX_FULL   = 9;
  localparam int STAT_W       = 10;

  // ****************************************************************
  // Line control fields and receive word layout.
  // ****************************************************************
  localparam int         CTL_MODE_LO    = 0;
  localparam int         CTL_PARITY_ODD = 5;
  localparam int         CTL_RUN        = 7;
  localparam int         CTL_RX_EN      = 8;
  localparam int         CTRL_W         = 11;
  localparam logic [2:0] MODE_8_PARITY  = 3'h7;
  localparam int         RX_PE_BIT      = 8;
  localparam int         RX_FE_BIT      = 9;
  localparam int         GAP_W          = 8;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [15:0]       BAUD_RST = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [STAT_W-1:0] MASK_RST = 10'h000;
  localparam logic [GAP_W-1:0]  GAP_RST  = 8'h00;

  // ****************************************************************
  // Oversampling: sixteen sub-ticks per bit, sample in the middle.
  // ****************************************************************
  localparam int        OS_W    = 4;
  localparam logic [3:0] OS_MID  = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hF;

  // One received character with its line faults.
  typedef struct packed {
    logic       frame_err;
    logic       parity_err;
    logic [7:0] data;
  } rx_entry_s;

endpackage : uart_pkg

`default_nettype wire

// ==== tb/uart_fifo_status_timeout_assertions.sv ====
// Checker for the serial port queue block, seeing only its top ports.
// Assumes one AHB-Lite master.
`default_nettype none
module uart_fifo_status_timeout_assertions
  import uart_pkg::*;
(
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Register bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Line and interrupt.
  input wire logic        txd,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Mirrors
  // ****
  logic        tk;
  logic        wv_q;
  logic [7:0]  wa_q;
  logic [7:0]  gap_q;
  logic [9:0]  mask_q;
  logic        txw_q;
  assign tk = hsel && hready && htrans[1];
  // Address phase kept for the data phase.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wv_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wv_q <= tk && hwrite;
      wa_q <= haddr[7:0];
    end
  end
  // Own copies of limit and mask.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q  <= 8'h00;
      mask_q <= 10'h000;
      txw_q  <= 1'b0;
    end else if (wv_q) begin
      if (wa_q == OFS_GAP) gap_q <= hwdata[7:0];
      if (wa_q == OFS_MASK) mask_q <= hwdata[9:0];
      if (wa_q == OFS_TXH) txw_q <= 1'b1;
    end
  end
  sequence wr_to(logic [7:0] a);
    tk && hwrite && haddr[7:0] == a;
  endsequence
  sequence rd_of(logic [7:0] a);
    tk && !hwrite && haddr[7:0] == a;
  endsequence
  gap_read_a:
    assert property (rd_of(OFS_GAP) |=> hrdata == {24'h00_0000, gap_q})
    else $error("limit read differs");
  tx_flush_a:
    assert property (wr_to(OFS_TXFL) ##2 rd_of(OFS_STAT)
      |=> !hrdata[ST_TX_FULL] && hrdata[ST_TX_HALF]) else $error("tx flush left data");
  rx_flush_a:
    assert property (wr_to(OFS_RXFL) ##2 rd_of(OFS_STAT)
      |=> (hrdata[9:0] & 10'h119) == 10'h000) else $error("rx flush left data");
  mask_quiet_a:
    assert property (mask_q == 10'h000 && $past(mask_q) == 10'h000 |-> !irq)
    else $error("irq with all masked");
  full_half_a:
    assert property (rd_of(OFS_STAT) |=> hrdata[31:10] == 22'h00_0000
      && !(hrdata[ST_TX_FULL] && hrdata[ST_TX_HALF])) else $error("tx flags clash");
  half_entry_a:
    assert property (rd_of(OFS_STAT) |=> !hrdata[ST_RX_HALF] || hrdata[ST_RX_ENTRY])
    else $error("half full yet empty");
  fault_entry_a:
    assert property (rd_of(OFS_STAT)
      |=> !(hrdata[ST_PARITY] || hrdata[ST_FRAME]) || hrdata[ST_RX_ENTRY])
    else $error("fault on empty queue");
  txd_quiet_a:
    assert property (!txw_q |-> txd) else $error("txd moved while idle");
endmodule : uart_fifo_status_timeout_assertions
bind uart_fifo_status_timeout uart_fifo_status_timeout_assertions u_chk (
  .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .txd, .irq);
`default_nettype wire

// ==== tb/uart_line_partner.sv ====
// Remote transceiver model on the serial line.
// Assumes divisor zero, eight data bits, even parity.
`default_nettype none
module uart_line_partner #(
  parameter int BIT_CYC = 16
) (
  // Clock.
  input  wire logic core_clk,
  // Serial line.
  output var logic  rxd,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] sh;
  logic [9:0]  got_q;
  // Line idles high.
  initial rxd = 1'b1;
  // One frame; flags spoil the parity or stop bit.
  task automatic send(input logic [7:0] d, input logic bad_par, bad_stop);
    logic [10:0] f;
    f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
    // A broken stop needs an idle bit, or the next start is lost.
    if (bad_stop) begin
      rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask : send
  // Sample outgoing frames mid-bit into stop, parity, data.
  initial got_q = 10'h000;
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 11; i++) begin
      sh[i] = txd;
      repeat (BIT_CYC) @(posedge core_clk);
    end
    got_q = sh[10:1];
  end
endmodule : uart_line_partner
`default_nettype wire

// ==== tb/test_uart_fifo_status_timeout.sv ====
// Self-checking bench for the serial port queue block.
// Assumes the line partner model and the bound checker.
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module test_uart_fifo_status_timeout
  import uart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench
  // ****
  logic        core_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        rxd;
  logic        txd;
  logic        irq;
  logic [31:0] q;
  logic [31:0] ev;
  int          miscompares;
  int          tests_run;
  assign hready = hreadyout;
  always #5 core_clk = ~core_clk;
  uart_fifo_status_timeout u_uart_fifo_status_timeout (
    .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .rxd, .txd, .irq);
  uart_line_partner u_uart_line_partner (.core_clk, .rxd, .txd);
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bounded wait for hready.
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
  endtask : edge_rdy
  // Address phase, then data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    edge_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy();
    q = hrdata;
    `CHK("response", 0, hresp);
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string n);
    xfer(1'b0, a, 32'h0);
    `CHK(n, e, q & m);
  endtask : rd_chk
  // Poll status until the masked bits match.
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_STAT, 32'h0);
      n++;
    end while ((q & m) !== e && n < 400);
    `CHK("poll", e, q & m);
    if ((q & m) !== e) give_verdict();
  endtask : poll
  // Main sequence.
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    miscompares = 0;
    tests_run = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(OFS_STAT, 32'h0000_03FF, 32'h0000_0006, "status");
    rd_chk(OFS_GAP, 32'hFFFF_FFFF, 32'h0, "limit");
    xfer(1'b1, OFS_GAP, 32'h0000_FF04);
    rd_chk(OFS_GAP, 32'hFFFF_FFFF, 32'h0000_0004, "limit");
    xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'hFFFF_FFFF, 32'h0, "unmapped");
    $display("Finished registers");
    // Fill the stopped transmit queue, then flush.
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, OFS_TXH, 32'(i));
      ev = (i < 8) ? 32'h0000_0006 : 32'h0000_0002;
      ev[ST_TX_FULL] = (i == 15);
      rd_chk(OFS_STAT, 32'h0000_0206, ev, "tx level");
    end
    xfer(1'b1, OFS_TXFL, 32'h0);
    rd_chk(OFS_STAT, 32'h0000_0206, 32'h0000_0006, "tx flush");
    xfer(1'b1, OFS_CTRL, 32'h0000_0187);
    xfer(1'b1, OFS_TXH, 32'h0000_0041);
    poll(32'h0000_0002, 32'h0);
    poll(32'h0000_0002, 32'h0000_0002);
    repeat (16) @(posedge core_clk);
    `CHK("line out", 32'h0000_0241, u_uart_line_partner.got_q);
    $display("Finished transmit");
    // Read one character; the limit then fires on an empty queue.
    xfer(1'b1, OFS_MASK, 32'h0000_0001);
    u_uart_line_partner.send(8'h5A, 1'b0, 1'b0);
    poll(32'h0000_0001, 32'h0000_0001);
    @(posedge core_clk);
    `CHK("irq", 1, irq);
    xfer(1'b1, OFS_MASK, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    `CHK("irq masked", 0, irq);
    rd_chk(OFS_RXH, 32'h0000_03FF, 32'h0000_005A, "rx char");
    poll(32'h0000_00C1, 32'h0000_0080);
    xfer(1'b1, OFS_STAT, 32'h0000_00E0);
    u_uart_line_partner.send(8'h00, 1'b0, 1'b0);
    poll(32'h0000_00C0, 32'h0000_0040);
    $display("Finished timeout");
    // Fill the receive queue with faults, overrun it, flush it.
    for (int i = 1; i < 16; i++) begin
      u_uart_line_partner.send(8'(i), i == 3, i == 5);
      rd_chk(OFS_STAT, 32'h0000_0100, (i >= 7) ? 32'h0000_0100 : 0, "half");
    end
    rd_chk(OFS_STAT, 32'h0000_0139, 32'h0000_0119, "rx faults");
    u_uart_line_partner.send(8'hFF, 1'b0, 1'b0);
    rd_chk(OFS_STAT, 32'h0000_0020, 32'h0000_0020, "overrun");
    xfer(1'b1, OFS_RXFL, 32'h0);
    rd_chk(OFS_STAT, 32'h0000_0119, 32'h0, "rx flush");
    $display("Finished receive");
    give_verdict();
  end
endmodule : test_uart_fifo_status_timeout
`default_nettype wire
